// ---- pkg/periodic_timer_pkg.sv ----
/*
  Shared constants and types of the 10-bit periodic timer: register offsets,
  field codes, reset values, the operating-mode decode and carrier structs.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
`default_nettype none

package periodic_timer_pkg;

  // ----------------------------------------------------------------------
  // sizes and register offsets
  // ----------------------------------------------------------------------
  localparam int CNT_W = 10;
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADR_W-1:0] OFS_COUNT  = 8'h04;
  localparam logic [ADR_W-1:0] OFS_DUTY   = 8'h08;
  localparam logic [ADR_W-1:0] OFS_PERIOD = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_FLAGS  = 8'h10;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  localparam int CTRL_W     = 9;

  // ----------------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_CMP     = 2'h0;
  localparam logic [1:0] MODE_CAP     = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TC      = 2'h3;
  localparam logic [1:0] ACT_INACTIVE = 2'h0;
  localparam logic [1:0] ACT_ACTIVE   = 2'h1;
  localparam logic [1:0] ACT_PWM      = 2'h2;
  localparam logic [1:0] ACT_PULSE    = 2'h3;
  localparam logic [1:0] CAP_RISE     = 2'h0;
  localparam logic [1:0] CAP_FALL     = 2'h1;
  localparam logic [1:0] CAP_BOTH     = 2'h2;
  localparam logic [1:0] CAP_OFF      = 2'h3;
  localparam logic [1:0] CMP_NONE     = 2'h0;
  localparam logic [1:0] CMP_LOW      = 2'h1;
  localparam logic [1:0] CMP_HIGH     = 2'h2;
  localparam logic [1:0] CMP_TOGGLE   = 2'h3;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic run_bit;
    logic mode_sel_hi;
    logic mode_sel_lo;
    logic out_action_hi;
    logic out_action_lo;
    logic output_level_ctl;
    logic output_invert;
    logic capture_source_sel;
    logic clear_select;
  } ctrl_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } edges_t;

  typedef enum logic [4:0] {
    OP_CMP   = 5'h01,
    OP_CAP   = 5'h02,
    OP_PWM   = 5'h04,
    OP_PULSE = 5'h08,
    OP_TC    = 5'h10
  } op_t;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam ctrl_t            CTRL_RST   = 9'h000;
  localparam logic [CNT_W-1:0] COUNT_RST  = 10'h000;
  localparam logic [CNT_W-1:0] DUTY_RST   = 10'h000;
  localparam logic [CNT_W-1:0] PERIOD_RST = 10'h000;
  localparam logic [1:0]       FLAGS_RST  = 2'h0;

  function automatic op_t decode_op(input ctrl_t c);
    logic [1:0] m;
    logic [1:0] a;
    m = {c.mode_sel_hi, c.mode_sel_lo};
    a = {c.out_action_hi, c.out_action_lo};
    decode_op = OP_CMP;
    unique case (m)
      MODE_CMP: decode_op = OP_CMP;
      MODE_CAP: decode_op = OP_CAP;
      MODE_PWM: decode_op = (a == ACT_PULSE) ? OP_PULSE : OP_PWM;
      MODE_TC:  decode_op = OP_TC;
    endcase
  endfunction

endpackage

`default_nettype wire

// ---- hw/pin_edge_watch.sv ----
/*
  Edge detector for one timer pin: one-cycle rise and fall pulses.
  Assumes the pin is already synchronous to the system clock.
*/
`timescale 1ns/100ps
`default_nettype none

module pin_edge_watch (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_pin,
  output var periodic_timer_pkg::edges_t o_edges
);

  logic prev_q;
  logic primed_q;

  // ----------------------------------------------------------------------
  // previous level, no edge before the first sample
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q   <= 1'b0;
      primed_q <= 1'b0;
    end else begin
      prev_q   <= i_pin;
      primed_q <= 1'b1;
    end
  end

  assign o_edges.rise = primed_q & i_pin & ~prev_q;
  assign o_edges.fall = primed_q & ~i_pin & prev_q;

endmodule

`default_nettype wire

// ---- hw/periodic_timer.sv ----
/*
  Periodic timer with duty and period comparators: compare, timer/counter,
  PWM, single pulse and capture modes, registers on classic Wishbone.
  Assumes synchronous pins and a one-cycle timer tick from a clock selector.
*/
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - clear-on-A compare: no period flag, pin on A
// - mode 11 is timer/counter, compare behaviour
// - timer/counter sets flags, pin not driven
// - mode 10 with action 10 is PWM
// - PWM period is period value, zero gives 1024
// - duty at or above period: always active
// - PWM sets one flag per comparator
// - PWM ignores clear-select
// - PWM: level bit polarity, invert bit reverses pin
// - PWM actions 00/01 force pin, counter runs
// - mode 10 with action 11 is single pulse
// - run rise starts counter and pulse
// - single pulse: external clock pin rising edge sets run bit
// - A match or software clear ends pulse
// - single pulse A match raises interrupt flag
// - single pulse counter zeroed only on run rise
// - mode 01 is capture, source chosen by bit
// - capture copies counter into duty, raises flag
// - capture counter free-runs until run falls
// - capture period match clears counter, raises flag
// - capture period zero wraps at maximum count
// - capture action 11 disables capture only
// - capture edges: 00 rise, 01 fall, 10 both
// - capture source: 0 input pin, 1 clock pin
// - output level 0 active low, 1 active high
// - counter, duty, period are 10 bits
module periodic_timer #(
  parameter int CNT_W = periodic_timer_pkg::CNT_W
) (
  input  wire logic                                i_clk_sys,
  input  wire logic                                i_rst_n,
  input  wire logic                                i_wb_cyc,
  input  wire logic                                i_wb_stb,
  input  wire logic                                i_wb_we,
  input  wire logic [periodic_timer_pkg::ADR_W-1:0] i_wb_adr,
  input  wire logic [3:0]                          i_wb_sel,
  input  wire logic [31:0]                         i_wb_dat,
  output logic      [31:0]                         o_wb_dat,
  output logic                                     o_wb_ack,
  input  wire logic                                i_timer_tick,
  input  wire logic                                i_capture_input_pin,
  input  wire logic                                i_ext_clock_pin,
  output logic                                     o_timer_output_pin,
  output logic                                     o_timer_output_oe
);

  if (CNT_W < 2 || CNT_W > 16) begin : g_width_check
    $error("periodic_timer: CNT_W must be 2 to 16");
  end

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  periodic_timer_pkg::ctrl_t  ctrl_q;
  periodic_timer_pkg::op_t    op;
  periodic_timer_pkg::edges_t cin_edges;
  periodic_timer_pkg::edges_t ext_edges;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] duty_q;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] nxt;
  logic [CNT_W:0]   period_eff;
  logic [1:0]       flags_q;
  logic [1:0]       flag_set;
  logic [1:0]       action;
  logic             run_prev_q;
  logic             cmp_lvl_q;
  logic             ack_q;
  logic             wb_hit;
  logic             wr_fire;
  logic             run_rise;
  logic             step;
  logic             a_match;
  logic             p_match;
  logic             clr;
  logic             run_set;
  logic             run_clr;
  logic             cap_fire;
  logic             pwm_active;
  logic             act_lvl;
  logic             pin_d;
  logic             oe_d;
  logic [31:0]      rdat_d;

  assign op     = periodic_timer_pkg::decode_op(ctrl_q);
  assign action = {ctrl_q.out_action_hi, ctrl_q.out_action_lo};

  // ----------------------------------------------------------------------
  // pin edges
  // ----------------------------------------------------------------------
  pin_edge_watch u_cin_edge (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_pin     (i_capture_input_pin),
    .o_edges   (cin_edges)
  );

  pin_edge_watch u_ext_edge (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_pin     (i_ext_clock_pin),
    .o_edges   (ext_edges)
  );

  // ----------------------------------------------------------------------
  // bus slave: ack one cycle after request, write at the ack edge
  // ----------------------------------------------------------------------
  assign wb_hit  = i_wb_cyc & i_wb_stb;
  assign wr_fire = wb_hit & i_wb_we & ack_q;

  always_comb begin
    rdat_d = 32'h0000_0000;
    unique case (i_wb_adr)
      periodic_timer_pkg::OFS_CTRL:   rdat_d[periodic_timer_pkg::CTRL_W-1:0] = ctrl_q;
      periodic_timer_pkg::OFS_COUNT:  rdat_d[CNT_W-1:0] = count_q;
      periodic_timer_pkg::OFS_DUTY:   rdat_d[CNT_W-1:0] = duty_q;
      periodic_timer_pkg::OFS_PERIOD: rdat_d[CNT_W-1:0] = period_q;
      periodic_timer_pkg::OFS_FLAGS:  rdat_d[1:0] = flags_q;
      default:                        rdat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_q    <= 1'b0;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      ack_q    <= wb_hit & ~ack_q;
      o_wb_ack <= wb_hit & ~ack_q;
      if (wb_hit & ~ack_q) begin
        o_wb_dat <= rdat_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // counting and comparators
  // ----------------------------------------------------------------------
  assign run_rise   = ctrl_q.run_bit & ~run_prev_q;
  assign step       = ctrl_q.run_bit & i_timer_tick & ~run_rise;
  assign nxt        = CNT_W'(count_q + 1'b1);
  assign a_match    = step && (duty_q != '0) && (nxt == duty_q);
  assign p_match    = step && (nxt == period_q);
  assign period_eff = {(period_q == '0), period_q};

  always_comb begin
    logic src;
    src      = ctrl_q.capture_source_sel ? i_ext_clock_pin : i_capture_input_pin;
    cap_fire = 1'b0;
    if (ctrl_q.capture_source_sel) begin
      unique case (action)
        periodic_timer_pkg::CAP_RISE: cap_fire = ext_edges.rise;
        periodic_timer_pkg::CAP_FALL: cap_fire = ext_edges.fall;
        periodic_timer_pkg::CAP_BOTH: cap_fire = ext_edges.rise | ext_edges.fall;
        periodic_timer_pkg::CAP_OFF:  cap_fire = 1'b0;
      endcase
    end else begin
      unique case (action)
        periodic_timer_pkg::CAP_RISE: cap_fire = cin_edges.rise;
        periodic_timer_pkg::CAP_FALL: cap_fire = cin_edges.fall;
        periodic_timer_pkg::CAP_BOTH: cap_fire = cin_edges.rise | cin_edges.fall;
        periodic_timer_pkg::CAP_OFF:  cap_fire = src & 1'b0;
      endcase
    end
    if (op != periodic_timer_pkg::OP_CAP) begin
      cap_fire = 1'b0;
    end
  end

  always_comb begin
    clr      = 1'b0;
    flag_set = 2'b00;
    run_clr  = 1'b0;
    unique case (op)
      periodic_timer_pkg::OP_CMP, periodic_timer_pkg::OP_TC: begin
        if (ctrl_q.clear_select) begin
          clr = a_match;
          flag_set[periodic_timer_pkg::FLAG_A_BIT] = a_match;
        end else begin
          clr = p_match;
          flag_set[periodic_timer_pkg::FLAG_A_BIT] = a_match;
          flag_set[periodic_timer_pkg::FLAG_P_BIT] = p_match;
        end
      end
      periodic_timer_pkg::OP_PWM: begin
        clr = p_match;
        flag_set[periodic_timer_pkg::FLAG_A_BIT] = a_match;
        flag_set[periodic_timer_pkg::FLAG_P_BIT] = p_match;
      end
      periodic_timer_pkg::OP_PULSE: begin
        run_clr = a_match;
        flag_set[periodic_timer_pkg::FLAG_A_BIT] = a_match;
      end
      periodic_timer_pkg::OP_CAP: begin
        clr = p_match;
        flag_set[periodic_timer_pkg::FLAG_A_BIT] = cap_fire;
        flag_set[periodic_timer_pkg::FLAG_P_BIT] = p_match;
      end
    endcase
  end

  assign run_set = (op == periodic_timer_pkg::OP_PULSE) & ext_edges.rise;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q    <= CNT_W'(periodic_timer_pkg::COUNT_RST);
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= ctrl_q.run_bit;
      if (run_rise) begin
        count_q <= '0;
      end else if (step) begin
        count_q <= clr ? '0 : nxt;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers written by software and hardware
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= periodic_timer_pkg::CTRL_RST;
    end else begin
      if (wr_fire && i_wb_adr == periodic_timer_pkg::OFS_CTRL) begin
        if (i_wb_sel[0]) begin
          ctrl_q[7:0] <= i_wb_dat[7:0];
        end
        if (i_wb_sel[1]) begin
          ctrl_q.run_bit <= i_wb_dat[8];
        end
      end
      if (run_clr) begin
        ctrl_q.run_bit <= 1'b0;
      end
      if (run_set) begin
        ctrl_q.run_bit <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      duty_q   <= CNT_W'(periodic_timer_pkg::DUTY_RST);
      period_q <= CNT_W'(periodic_timer_pkg::PERIOD_RST);
    end else begin
      if (wr_fire && i_wb_adr == periodic_timer_pkg::OFS_PERIOD) begin
        period_q <= i_wb_dat[CNT_W-1:0];
      end
      if (wr_fire && i_wb_adr == periodic_timer_pkg::OFS_DUTY) begin
        duty_q <= i_wb_dat[CNT_W-1:0];
      end
      if (cap_fire) begin
        duty_q <= count_q;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= periodic_timer_pkg::FLAGS_RST;
    end else if (wr_fire && i_wb_adr == periodic_timer_pkg::OFS_FLAGS && i_wb_sel[0]) begin
      flags_q <= (flags_q & ~i_wb_dat[1:0]) | flag_set;
    end else begin
      flags_q <= flags_q | flag_set;
    end
  end

  // ----------------------------------------------------------------------
  // output pin
  // ----------------------------------------------------------------------
  assign pwm_active = ({1'b0, duty_q} >= period_eff) || (count_q < duty_q);
  assign act_lvl    = ctrl_q.output_level_ctl ^ ctrl_q.output_invert;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_lvl_q <= 1'b0;
    end else if (run_rise) begin
      cmp_lvl_q <= ctrl_q.output_level_ctl;
    end else if (a_match && op == periodic_timer_pkg::OP_CMP) begin
      unique case (action)
        periodic_timer_pkg::CMP_NONE:   cmp_lvl_q <= cmp_lvl_q;
        periodic_timer_pkg::CMP_LOW:    cmp_lvl_q <= 1'b0;
        periodic_timer_pkg::CMP_HIGH:   cmp_lvl_q <= 1'b1;
        periodic_timer_pkg::CMP_TOGGLE: cmp_lvl_q <= ~cmp_lvl_q;
      endcase
    end
  end

  always_comb begin
    pin_d = 1'b0;
    oe_d  = 1'b0;
    unique case (op)
      periodic_timer_pkg::OP_CMP: begin
        oe_d  = 1'b1;
        pin_d = cmp_lvl_q ^ ctrl_q.output_invert;
      end
      periodic_timer_pkg::OP_PWM: begin
        oe_d = 1'b1;
        unique case (action)
          periodic_timer_pkg::ACT_ACTIVE: pin_d = act_lvl;
          periodic_timer_pkg::ACT_PWM:    pin_d = (ctrl_q.run_bit && pwm_active) ? act_lvl : ~act_lvl;
          default:                        pin_d = ~act_lvl;
        endcase
      end
      periodic_timer_pkg::OP_PULSE: begin
        oe_d  = 1'b1;
        pin_d = ctrl_q.run_bit ? act_lvl : ~act_lvl;
      end
      periodic_timer_pkg::OP_CAP, periodic_timer_pkg::OP_TC: begin
        oe_d  = 1'b0;
        pin_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_timer_output_pin <= 1'b0;
      o_timer_output_oe  <= 1'b0;
    end else begin
      o_timer_output_pin <= pin_d;
      o_timer_output_oe  <= oe_d;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);

  property p_no_pflag_on_a_clear;
    (op == periodic_timer_pkg::OP_CMP && ctrl_q.clear_select && !flags_q[1] && !wr_fire)
      |=> !flags_q[1];
  endproperty
  a_no_pflag_on_a_clear: assert property (p_no_pflag_on_a_clear) else $error("period flag set under clear-on-A");

  property p_tc_pin_free;
    op == periodic_timer_pkg::OP_TC |=> !o_timer_output_oe;
  endproperty
  a_tc_pin_free: assert property (p_tc_pin_free) else $error("pin driven in timer/counter mode");

  property p_pwm_period_clear;
    (op == periodic_timer_pkg::OP_PWM && p_match && !run_rise) |=> count_q == '0 && flags_q[1];
  endproperty
  a_pwm_period_clear: assert property (p_pwm_period_clear) else $error("pwm period match did not clear");

  property p_pwm_full_duty;
    (op == periodic_timer_pkg::OP_PWM && action == periodic_timer_pkg::ACT_PWM && ctrl_q.run_bit
      && {1'b0, duty_q} >= period_eff) |=> o_timer_output_pin == $past(act_lvl);
  endproperty
  a_pwm_full_duty: assert property (p_pwm_full_duty) else $error("full duty not held active");

  property p_pwm_forced_inactive;
    (op == periodic_timer_pkg::OP_PWM && action == periodic_timer_pkg::ACT_INACTIVE)
      |=> o_timer_output_pin == !$past(act_lvl);
  endproperty
  a_pwm_forced_inactive: assert property (p_pwm_forced_inactive) else $error("forced inactive level wrong");

  property p_ext_sets_run;
    run_set |=> ctrl_q.run_bit;
  endproperty
  a_ext_sets_run: assert property (p_ext_sets_run) else $error("clock pin edge did not set run");

  property p_pulse_ends_on_a;
    (op == periodic_timer_pkg::OP_PULSE && a_match && !run_set) |=> !ctrl_q.run_bit && flags_q[0]
      ##1 o_timer_output_pin == !$past(act_lvl);
  endproperty
  a_pulse_ends_on_a: assert property (p_pulse_ends_on_a) else $error("pulse not ended by A match");

  property p_capture_copies;
    cap_fire |=> duty_q == $past(count_q) && flags_q[0];
  endproperty
  a_capture_copies: assert property (p_capture_copies) else $error("capture did not load duty");

  property p_hold_when_stopped;
    (!ctrl_q.run_bit && !run_set) |=> $stable(count_q);
  endproperty
  a_hold_when_stopped: assert property (p_hold_when_stopped) else $error("counter moved while stopped");

  c_pwm_wrap:    cover property (op == periodic_timer_pkg::OP_PWM && p_match);
  c_pulse_end:   cover property (op == periodic_timer_pkg::OP_PULSE && run_clr);
  c_capture:     cover property (cap_fire);
  c_cap_max:     cover property (op == periodic_timer_pkg::OP_CAP && p_match && period_q == '0);

endmodule

`default_nettype wire

// ---- bench/pin_partner.sv ----
/*
  Pin-side partner of the timer: drives the capture and clock pins
  and resolves the output pin level. Assumes bench requests change after edges.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  input  wire logic i_clk_sys,
  input  wire logic i_cap_req,
  input  wire logic i_ext_req,
  input  wire logic i_pin,
  input  wire logic i_oe,
  output logic      o_cap,
  output logic      o_ext,
  output logic      o_seen
);
  logic last_q;
  initial begin
    o_cap = 1'b0;
    o_ext = 1'b0;
    last_q = 1'b0;
  end
  // pins move just after an edge, synchronous to the timer
  always @(posedge i_clk_sys) begin
    o_cap <= i_cap_req;
    o_ext <= i_ext_req;
    if (i_oe) last_q <= i_pin;
  end
  // undriven pin shows the inverse of its last level
  assign o_seen = i_oe ? i_pin : ~last_q;
endmodule
`default_nettype wire

// ---- bench/periodic_timer_tb.sv ----
/*
  Self-checking bench of the periodic timer: reads queue expected words and
  a monitor compares them at ack. Assumes pin_partner on the pin side.
*/
`timescale 1ns/100ps
`default_nettype none
module periodic_timer_tb;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, tick = 1'b0;
  logic cap_req = 1'b0, ext_req = 1'b0, rnd = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, pin, oe, capp, extp, seen;
  logic [31:0] exp_q[$];
  string nm_q[$];
  int bad_count = 0, checks_done = 0, seed = 95594, n;
  logic [8:0] pwm_c [4] = '{9'h1A8, 9'h1AC, 9'h188, 9'h198};
  logic pwm_e [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  always #2.5 clk = ~clk;
  periodic_timer uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc),
    .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_timer_tick(tick),
    .i_capture_input_pin(capp), .i_ext_clock_pin(extp),
    .o_timer_output_pin(pin), .o_timer_output_oe(oe));
  pin_partner ptn (.i_clk_sys(clk), .i_cap_req(cap_req), .i_ext_req(ext_req),
    .i_pin(pin), .i_oe(oe), .o_cap(capp), .o_ext(extp), .o_seen(seen));
  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
    chk(nm_q.pop_front(), exp_q.pop_front(), rdat);
  always @(posedge clk) if (rnd) tick <= 1'($random(seed));
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string s);
    exp_q.push_back(e);
    nm_q.push_back(s);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic hold(logic e, string s);
    repeat (16) begin
      @(posedge clk);
      chk(s, {31'h0, e}, {31'h0, seen});
    end
  endtask
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (n = 0; n < 6; n++) rd(8'(n * 4), 32'h0, "reset value");
    n = $random(seed);
    wr(8'h08, 32'(n));
    rd(8'h08, 32'(n) & 32'h3FF, "duty");
    $display("test registers done");
    rnd <= 1'b1;
    wr(8'h0C, 32'h4);
    wr(8'h08, 32'h1);
    wr(8'h10, 32'h3);
    wr(8'h00, 32'h1A8);
    repeat (40) @(posedge clk);
    rd(8'h10, 32'h3, "pwm flags");
    wr(8'h08, 32'h5);
    for (n = 0; n < 4; n++) begin
      wr(8'h00, 32'h0);
      wr(8'h00, {24'h0, pwm_c[n][7:0]});
      wr(8'h00, {23'h0, pwm_c[n]});
      repeat (4) @(posedge clk);
      hold(pwm_e[n], "pwm pin");
    end
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h1C0);
    repeat (2) @(posedge clk);
    chk("tc oe", 32'h0, {31'h0, oe});
    wr(8'h00, 32'h0C0);
    $display("test pwm done");
    rnd <= 1'b0;
    @(posedge clk);
    tick <= 1'b0;
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h3);
    wr(8'h00, 32'h140);
    repeat (3) @(posedge clk);
    n = 1 + ($random(seed) & 15);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge clk);
    end
    tick <= 1'b0;
    wr(8'h00, 32'h040);
    cap_req <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h08, 32'(n), "captured count");
    rd(8'h10, 32'h1, "capture flag");
    wr(8'h10, 32'h3);
    wr(8'h00, 32'h070);
    cap_req <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h10, 32'h0, "capture off");
    wr(8'h00, 32'h052);
    ext_req <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h10, 32'h0, "rise ignored");
    ext_req <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h10, 32'h1, "fall taken");
    $display("test capture done");
    rnd <= 1'b1;
    wr(8'h10, 32'h3);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h0B8);
    ext_req <= 1'b1;
    repeat (60) @(posedge clk);
    rd(8'h00, 32'h0B8, "run after pulse");
    rd(8'h10, 32'h1, "pulse flag");
    $display("test pulse done");
    wr(8'h10, 32'h3);
    wr(8'h0C, 32'h2);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h101);
    repeat (40) @(posedge clk);
    rd(8'h10, 32'h1, "clear on A flags");
    $display("test compare done");
    report_and_stop();
  end
endmodule
`default_nettype wire
